//--- rtl/mse_exec.v
`timescale 1ns/1ps
`include "mse_consts.vh"

// Contract
// RQ1: Minus-one-into-working-register writes memory value minus one to the working register, memory untouched.
// RQ2: The power-down instruction stops fetch and execution and gates off the system clock.
// RQ3: Entering and staying in power-down keeps all memory and register contents unchanged.
// RQ4: The power-down instruction clears the watchdog counter and its prescaler.
// RQ5: The power-down instruction sets the sleep bit, clears the expiry bit and advances the program counter by one;
// the code leaves the expiry bit set when a watchdog expiry arrives in the same cycle.
// RQ6: Increment-in-memory adds one to the addressed location and writes it back there.
// RQ7: Add-one-into-working-register puts memory value plus one in the working register, memory untouched.
// RQ8: Direct branch loads the program counter with the encoded target unconditionally.
// RQ9: Memory-to-working-register copy loads the working register from the addressed location.
// RQ10: Immediate load puts the 8-bit constant of the instruction into the working register.
// RQ11: Working-register-to-memory copy stores the working register into the addressed location.
// RQ12: The branch and the three copies leave every status flag unchanged.
// RQ13: Increments and decrements set the zero flag from their result and leave other flags alone.
module mse_exec #(
    parameter PC_W  = `MSE_PC_W,
    parameter AW    = `MSE_MADDR_W,
    parameter DEPTH = `MSE_MEM_DEPTH
) (
    input  wire                   core_clk,
    input  wire                   resetn,
    input  wire                   instr_valid,
    input  wire [3:0]             instr_op,
    input  wire [AW-1:0]          instr_maddr,
    input  wire [`MSE_DATA_W-1:0] instr_imm,
    input  wire [PC_W-1:0]        instr_target,
    input  wire                   wake_pin,
    input  wire                   watchdog_expire,
    input  wire [AW-1:0]          dbg_addr,
    output reg                    instr_ready_reg,
    output reg                    exec_done_reg,
    output reg  [PC_W-1:0]        pc_reg,
    output reg  [`MSE_DATA_W-1:0] working_register_reg,
    output reg  [7:0]             status_reg,
    output reg                    sys_clk_en_reg,
    output reg                    watchdog_clear_reg,
    output reg  [`MSE_DATA_W-1:0] dbg_data_reg
);

    localparam ST_RUN   = 1'b0;
    localparam ST_SLEEP = 1'b1;

    reg                    state_reg;
    reg                    state_next;
    reg                    wake_s1_reg;
    reg                    wake_s2_reg;

    localparam HOT_MINUS  = 0;
    localparam HOT_SLEEP  = 1;
    localparam HOT_INC    = 2;
    localparam HOT_PLUS   = 3;
    localparam HOT_BRANCH = 4;
    localparam HOT_CP_MW  = 5;
    localparam HOT_CP_IW  = 6;
    localparam HOT_CP_WM  = 7;
    localparam HOT_W      = 8;

    reg  [PC_W-1:0]        pc_next;
    reg  [`MSE_DATA_W-1:0] wreg_next;
    wire [7:0]             status_next;
    reg                    ready_next;
    reg                    done_next;
    reg                    clk_en_next;
    reg                    watchdog_clear_next;

    reg                    mem_wr_en;
    reg  [`MSE_DATA_W-1:0] mem_wr_data;
    wire [`MSE_DATA_W-1:0] mem_rd_data;
    wire [`MSE_DATA_W-1:0] dbg_rd_data;

    wire                   take;
    wire [`MSE_DATA_W-1:0] mem_plus;
    wire [`MSE_DATA_W-1:0] mem_minus;
    wire [PC_W-1:0]        pc_step;

    // One strobe per accepted opcode
    wire                   do_minus_wreg;
    wire                   do_sleep;
    wire                   do_inc_mem;
    wire                   do_plus_wreg;
    wire                   do_branch;
    wire                   do_copy_mw;
    wire                   do_copy_iw;
    wire                   do_copy_wm;
    wire                   do_arith;

    // Per-bit status update controls
    wire [7:0]             st_set_mask;
    wire [7:0]             st_clr_mask;
    wire [7:0]             st_load_mask;
    wire [7:0]             st_load_val;
    wire [7:0]             st_hold;
    wire                   zero_result;
    wire                   wake_seen;

    reg  [HOT_W-1:0]       op_hot;
    reg  [`MSE_DATA_W-1:0] arith_result;

    assign take      = instr_valid && instr_ready_reg && (state_reg == ST_RUN);
    assign mem_plus  = mem_rd_data + 8'h01;
    assign mem_minus = mem_rd_data - 8'h01;
    assign pc_step   = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};

    // Opcode decode; codes outside the subset fall through as no-op
    always @* begin
        op_hot = {HOT_W{1'b0}};
        case (instr_op)
            `MSE_OP_MINUS_WREG: op_hot[HOT_MINUS]  = 1'b1;
            `MSE_OP_HALT:       op_hot[HOT_SLEEP]  = 1'b1;
            `MSE_OP_INC:        op_hot[HOT_INC]    = 1'b1;
            `MSE_OP_PLUS_WREG:  op_hot[HOT_PLUS]   = 1'b1;
            `MSE_OP_BRANCH:     op_hot[HOT_BRANCH] = 1'b1;
            `MSE_OP_COPY_MW:    op_hot[HOT_CP_MW]  = 1'b1;
            `MSE_OP_COPY_IW:    op_hot[HOT_CP_IW]  = 1'b1;
            `MSE_OP_COPY_WM:    op_hot[HOT_CP_WM]  = 1'b1;
            default:            op_hot = {HOT_W{1'b0}};
        endcase
    end

    assign do_minus_wreg = take && op_hot[HOT_MINUS];
    assign do_sleep      = take && op_hot[HOT_SLEEP];
    assign do_inc_mem    = take && op_hot[HOT_INC];
    assign do_plus_wreg  = take && op_hot[HOT_PLUS];
    assign do_branch     = take && op_hot[HOT_BRANCH];
    assign do_copy_mw    = take && op_hot[HOT_CP_MW];
    assign do_copy_iw    = take && op_hot[HOT_CP_IW];
    assign do_copy_wm    = take && op_hot[HOT_CP_WM];
    assign do_arith      = do_minus_wreg || do_inc_mem || do_plus_wreg;
    assign wake_seen     = (state_reg == ST_SLEEP) && wake_s2_reg;

    // One adder result feeds the zero flag
    always @* begin
        arith_result = mem_plus;
        if (do_minus_wreg) begin
            arith_result = mem_minus;
        end
    end
    // RQ13 zero from the produced result
    assign zero_result = (arith_result == 8'h00);

    // Expiry pulse is on this clock already, no sync needed
    // RQ5 sleep bit set, expiry bit cleared
    assign st_set_mask  = ({7'h00, do_sleep} << `MSE_ST_SLEEP) |
                          ({7'h00, watchdog_expire} << `MSE_ST_EXPIRY);
    assign st_clr_mask  = ({7'h00, do_sleep} << `MSE_ST_EXPIRY);
    // RQ12 only the zero bit may load; every other flag holds
    assign st_load_mask = ({7'h00, do_arith} << `MSE_ST_Z);
    assign st_load_val  = ({7'h00, zero_result} << `MSE_ST_Z);
    assign st_hold      = (status_reg & ~st_load_mask) | (st_load_val & st_load_mask);

    // Status bits, one update cell each
    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_st
            // Set wins over clear so a same-cycle expiry is never lost
            assign status_next[b] = st_set_mask[b] || (!st_clr_mask[b] && st_hold[b]);
        end
    endgenerate

    mse_dmem #(
        .DEPTH (DEPTH),
        .AW    (AW),
        .DW    (`MSE_DATA_W)
    ) u_dmem (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (mem_wr_en),
        .wr_addr  (instr_maddr),
        .wr_data  (mem_wr_data),
        .rd_addr  (instr_maddr),
        .rd_data  (mem_rd_data),
        .dbg_addr (dbg_addr),
        .dbg_data (dbg_rd_data)
    );

    // Wake arrives from a pin; two flops before use
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end else begin
            wake_s1_reg <= wake_pin;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                // RQ2 stop fetch and execution
                if (do_sleep) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_seen) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // Handshake and gate outputs follow the state change
    always @* begin
        ready_next          = instr_ready_reg;
        clk_en_next         = sys_clk_en_reg;
        watchdog_clear_next = 1'b0;
        done_next           = take;
        if (do_sleep) begin
            ready_next  = 1'b0;
            // RQ2 gate the system clock
            clk_en_next = 1'b0;
            // RQ4 watchdog and prescaler cleared
            watchdog_clear_next = 1'b1;
        end else if (wake_seen) begin
            ready_next  = 1'b1;
            clk_en_next = 1'b1;
        end
    end

    // Program counter path; unknown codes still step
    always @* begin
        pc_next = pc_reg;
        if (do_branch) begin
            // RQ8 unconditional target load
            pc_next = instr_target;
        end else if (take) begin
            // RQ5 sleep entry also steps by one
            pc_next = pc_step;
        end
    end

    // Working register path
    always @* begin
        wreg_next = working_register_reg;
        if (do_minus_wreg) begin
            // RQ1 minus one, memory kept
            wreg_next = mem_minus;
        end else if (do_plus_wreg) begin
            // RQ7 plus one, memory kept
            wreg_next = mem_plus;
        end else if (do_copy_mw) begin
            // RQ9 memory to working register
            wreg_next = mem_rd_data;
        end else if (do_copy_iw) begin
            // RQ10 immediate to working register
            wreg_next = instr_imm;
        end
    end

    // RQ3 take is low asleep, so no writes
    always @* begin
        mem_wr_en   = 1'b0;
        mem_wr_data = working_register_reg;
        if (do_inc_mem) begin
            // RQ6 write back to same location
            mem_wr_en   = 1'b1;
            mem_wr_data = mem_plus;
        end else if (do_copy_wm) begin
            // RQ11 working register to memory
            mem_wr_en   = 1'b1;
        end
    end

    // RQ12 copies and branch keep status via default hold
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg            <= ST_RUN;
            pc_reg               <= `MSE_RST_PC;
            working_register_reg <= `MSE_RST_WREG;
            status_reg           <= `MSE_RST_STATUS;
            instr_ready_reg      <= 1'b0;
            exec_done_reg        <= 1'b0;
            sys_clk_en_reg       <= 1'b1;
            watchdog_clear_reg   <= 1'b0;
            dbg_data_reg         <= `MSE_RST_MEM;
        end else begin
            state_reg            <= state_next;
            pc_reg               <= pc_next;
            working_register_reg <= wreg_next;
            status_reg           <= status_next;
            // Ready rises one edge after reset release
            instr_ready_reg      <= (state_next == ST_RUN) ? 1'b1 : ready_next;
            exec_done_reg        <= done_next;
            sys_clk_en_reg       <= clk_en_next;
            watchdog_clear_reg   <= watchdog_clear_next;
            dbg_data_reg         <= dbg_rd_data;
        end
    end

endmodule

//--- rtl/mse_consts.vh
`ifndef MSE_CONSTS_VH
`define MSE_CONSTS_VH

// Instruction codes on instr_op
`define MSE_OP_NOP      4'h0
`define MSE_OP_MINUS_WREG 4'h1
`define MSE_OP_HALT     4'h2
`define MSE_OP_INC      4'h3
`define MSE_OP_PLUS_WREG 4'h4
`define MSE_OP_BRANCH   4'h5
`define MSE_OP_COPY_MW  4'h6
`define MSE_OP_COPY_IW  4'h7
`define MSE_OP_COPY_WM  4'h8

// Status bit positions
`define MSE_ST_C        0
`define MSE_ST_AC       1
`define MSE_ST_Z        2
`define MSE_ST_OV       3
`define MSE_ST_SLEEP    4
`define MSE_ST_EXPIRY   5
`define MSE_ST_TC1      6
`define MSE_ST_TC2      7

// Reset values
`define MSE_RST_PC      13'h0000
`define MSE_RST_WREG    8'h00
`define MSE_RST_STATUS  8'h00
`define MSE_RST_MEM     8'h00

// Widths of documented quantities
`define MSE_DATA_W      8
`define MSE_PC_W        13
`define MSE_MADDR_W     8
`define MSE_MEM_DEPTH   256

`endif

//--- rtl/mse_dmem.v
`timescale 1ns/1ps
`include "mse_consts.vh"

module mse_dmem #(
    parameter DEPTH = `MSE_MEM_DEPTH,
    parameter AW    = `MSE_MADDR_W,
    parameter DW    = `MSE_DATA_W
) (
    input  wire          core_clk,
    input  wire          resetn,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_addr,
    output wire [DW-1:0] rd_data,
    input  wire [AW-1:0] dbg_addr,
    output wire [DW-1:0] dbg_data
);

    reg  [DW-1:0] mem_reg [0:DEPTH-1];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            localparam [AW-1:0] IDX = i;
            // Only the addressed entry moves; the rest hold, also in sleep
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    mem_reg[i] <= `MSE_RST_MEM;
                end else if (wr_en && (wr_addr == IDX)) begin
                    mem_reg[i] <= wr_data;
                end
            end
        end
    endgenerate

    assign rd_data  = mem_reg[rd_addr];
    assign dbg_data = mem_reg[dbg_addr];

endmodule

//--- testbench/mse_exec_monitor.sv
`timescale 1ns/1ps
`include "mse_consts.vh"

module mse_exec_monitor (
    input wire        core_clk,
    input wire        resetn,
    input wire        instr_valid,
    input wire [3:0]  instr_op,
    input wire [7:0]  instr_imm,
    input wire [12:0] instr_target,
    input wire        watchdog_expire,
    input wire        instr_ready_reg,
    input wire [12:0] pc_reg,
    input wire [7:0]  working_register_reg,
    input wire [7:0]  status_reg,
    input wire        sys_clk_en_reg,
    input wire        watchdog_clear_reg
);
    wire tk = instr_valid && instr_ready_reg;
    // Expiry pulse wins over flag rules
    wire tq = tk && !watchdog_expire;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    jmp_target_a: assert property (
        tk && instr_op == `MSE_OP_BRANCH |=> pc_reg == $past(instr_target)) else $error("jump target not loaded");
    imm_load_a: assert property (
        tk && instr_op == `MSE_OP_COPY_IW |=> working_register_reg == $past(instr_imm)) else $error("immediate lost");
    halt_flags_a: assert property (
        tq && instr_op == `MSE_OP_HALT |=> status_reg[`MSE_ST_SLEEP] && !status_reg[`MSE_ST_EXPIRY]
        && pc_reg == $past(pc_reg) + 13'h0001) else $error("sleep entry flags or pc wrong");
    halt_gate_a: assert property (
        tk && instr_op == `MSE_OP_HALT |=> !sys_clk_en_reg && !instr_ready_reg) else $error("clock not gated");
    halt_wdt_a: assert property (
        tk && instr_op == `MSE_OP_HALT |=> watchdog_clear_reg ##1 !watchdog_clear_reg)
        else $error("watchdog clear pulse wrong");
    sleep_hold_a: assert property (
        !sys_clk_en_reg |=> $stable(pc_reg) && $stable(working_register_reg)) else $error("state moved while asleep");
    copy_flags_a: assert property (
        tq && instr_op inside {`MSE_OP_BRANCH, `MSE_OP_COPY_MW, `MSE_OP_COPY_IW, `MSE_OP_COPY_WM}
        |=> status_reg == $past(status_reg)) else $error("flags moved on copy or branch");
    incdec_flags_a: assert property (
        tq && instr_op inside {`MSE_OP_MINUS_WREG, `MSE_OP_INC, `MSE_OP_PLUS_WREG}
        |=> (status_reg & 8'hFB) == ($past(status_reg) & 8'hFB)) else $error("non-zero flag moved");
endmodule

bind mse_exec mse_exec_monitor mse_exec_monitor_inst (
    .core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_imm(instr_imm), .instr_target(instr_target), .watchdog_expire(watchdog_expire),
    .instr_ready_reg(instr_ready_reg), .pc_reg(pc_reg), .working_register_reg(working_register_reg),
    .status_reg(status_reg), .sys_clk_en_reg(sys_clk_en_reg), .watchdog_clear_reg(watchdog_clear_reg));

//--- testbench/tb_mse_exec.sv
`timescale 1ns/1ps
`include "mse_consts.vh"

module tb_mse_exec;
    reg         core_clk, resetn, instr_valid, wake_pin, watchdog_expire;
    reg  [3:0]  instr_op;
    reg  [7:0]  instr_maddr, instr_imm, dbg_addr, m;
    reg  [12:0] instr_target, p;
    wire        instr_ready_reg, exec_done_reg, sys_clk_en_reg, watchdog_clear_reg;
    wire [12:0] pc_reg;
    wire [7:0]  working_register_reg, status_reg, dbg_data_reg;
    integer     failures, total_checks, i;

    mse_exec mse_exec_inst (.core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_maddr(instr_maddr), .instr_imm(instr_imm), .instr_target(instr_target),
        .wake_pin(wake_pin), .watchdog_expire(watchdog_expire), .dbg_addr(dbg_addr),
        .instr_ready_reg(instr_ready_reg),
        .exec_done_reg(exec_done_reg), .pc_reg(pc_reg), .working_register_reg(working_register_reg),
        .status_reg(status_reg), .sys_clk_en_reg(sys_clk_en_reg), .watchdog_clear_reg(watchdog_clear_reg),
        .dbg_data_reg(dbg_data_reg));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // Valid stays high on exit so back-to-back calls never toggle it twice
    task op(input [3:0] o, input [7:0] a, input [7:0] x, input [12:0] t);
        begin
            instr_valid = 1'b1;
            instr_op = o;
            instr_maddr = a;
            instr_imm = x;
            instr_target = t;
            @(posedge core_clk);
            #1;
        end
    endtask

    task rd(input [7:0] a);
        begin
            instr_valid = 1'b0;
            dbg_addr = a;
            @(posedge core_clk);
            #1;
            m = dbg_data_reg;
        end
    endtask

    task t_moves;
        begin
            op(`MSE_OP_COPY_IW, 8'h00, 8'hA5, 13'h0000);
            chk(working_register_reg, 8'hA5);
            chk(exec_done_reg, 1'b1);
            op(`MSE_OP_COPY_WM, 8'h10, 8'h00, 13'h0000);
            op(`MSE_OP_COPY_IW, 8'h00, 8'h00, 13'h0000);
            op(`MSE_OP_COPY_MW, 8'h10, 8'h00, 13'h0000);
            chk(working_register_reg, 8'hA5);
            rd(8'h10);
            chk(m, 8'hA5);
            chk(exec_done_reg, 1'b0);
            chk(status_reg, 8'h00);
        end
    endtask

    task t_arith_branch;
        begin
            op(`MSE_OP_COPY_IW, 8'h00, 8'hFF, 13'h0000);
            op(`MSE_OP_COPY_WM, 8'h20, 8'h00, 13'h0000);
            op(`MSE_OP_PLUS_WREG, 8'h20, 8'h00, 13'h0000);
            chk(working_register_reg, 8'h00);
            chk(status_reg, 8'h04);
            op(`MSE_OP_MINUS_WREG, 8'h20, 8'h00, 13'h0000);
            chk(working_register_reg, 8'hFE);
            chk(status_reg, 8'h00);
            op(`MSE_OP_INC, 8'h20, 8'h00, 13'h0000);
            chk(status_reg, 8'h04);
            op(`MSE_OP_BRANCH, 8'h00, 8'h00, 13'h1ABC);
            chk(pc_reg, 13'h1ABC);
            chk(status_reg, 8'h04);
            op(`MSE_OP_MINUS_WREG, 8'h20, 8'h00, 13'h0000);
            chk(working_register_reg, 8'hFF);
            rd(8'h20);
            chk(m, 8'h00);
        end
    endtask

    task t_halt;
        begin
            watchdog_expire = 1'b1;
            @(posedge core_clk);
            #1;
            watchdog_expire = 1'b0;
            p = pc_reg;
            // Valid stays high after halt; a sleeping core must ignore the immediate load offered next
            op(`MSE_OP_HALT, 8'h00, 8'h00, 13'h0000);
            chk(status_reg, 8'h10);
            chk(pc_reg, p + 13'h0001);
            chk(sys_clk_en_reg, 1'b0);
            chk(watchdog_clear_reg, 1'b1);
            instr_op = `MSE_OP_COPY_IW;
            instr_imm = 8'h5A;
            repeat (4) @(posedge core_clk);
            #1;
            chk(watchdog_clear_reg, 1'b0);
            chk(pc_reg, p + 13'h0001);
            chk(working_register_reg, 8'hFF);
            rd(8'h20);
            chk(m, 8'h00);
            wake_pin = 1'b1;
            for (i = 0; i < 8 && instr_ready_reg !== 1'b1; i = i + 1) begin
                @(posedge core_clk);
                #1;
            end
            wake_pin = 1'b0;
            chk(instr_ready_reg, 1'b1);
            chk(working_register_reg, 8'hFF);
        end
    endtask

    task final_report;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    initial begin
        #100000;
        failures = failures + 1;
        final_report;
    end

    initial begin
        {resetn, instr_valid, wake_pin, watchdog_expire, instr_op} = 8'h00;
        {instr_maddr, instr_imm, dbg_addr, instr_target} = 37'h0;
        failures = 0;
        total_checks = 0;
        repeat (12) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        @(posedge core_clk);
        #1;
        t_moves;
        t_arith_branch;
        t_halt;
        final_report;
    end
endmodule
